// *** flash_seq_pkg.sv ***
package flash_seq_pkg;
  // array geometry: 16 primary + 4 secondary sectors, small word count per sector
  localparam int SECTORS = 20;
  localparam int PRI_SECTORS = 16;
  localparam int WORD_BITS = 4;
  localparam int MEM_WORDS = 320;
  localparam logic [8:0] MEM_LAST = 9'h13f;

  // instruction codes and unlock addresses
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [11:0] ADDR_UNLOCK1 = 12'haaa;
  localparam logic [11:0] ADDR_UNLOCK2 = 12'h554;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_PROG = 8'ha0;
  localparam logic [7:0] CMD_BYP_EXIT1 = 8'h90;
  localparam logic [7:0] CMD_BYP_EXIT2 = 8'h00;
  localparam logic [7:0] CMD_PROT_READ = 8'h90;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_BULK = 8'h10;
  localparam logic [7:0] CMD_SECTOR = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [15:0] PRECHARGE_WORD = 16'h0000;

  // status bit positions, upper byte mirrors them for the alternate bus format
  localparam int ST_POLL = 7;
  localparam int ST_TOGGLE = 6;
  localparam int ST_ERROR = 5;
  localparam int ST_TIMEOUT = 3;

  // timing
  localparam int CLK_NS = 8;
  localparam int WINDOW_NS = 100000;
  localparam int WINDOW_CYC = (WINDOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOVER_NS = 25000;
  localparam logic [13:0] RECOVER_CYC = 14'((RECOVER_NS + CLK_NS - 1) / CLK_NS);
  localparam int SUSP_MIN_NS = 100;
  localparam logic [13:0] SUSP_CYC = 14'((SUSP_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [13:0] PROG_CYC = 14'h0008;
  localparam logic [2:0] ERASE_TRIES = 3'h4;

  // controller register offsets (byte addresses)
  localparam logic [7:0] REG_ADDR = 8'h00;
  localparam logic [7:0] REG_WDATA = 8'h04;
  localparam logic [7:0] REG_RDGO = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [7:0] REG_SEL = 8'h14;
  localparam logic [7:0] REG_RST = 8'h18;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [17:0] {
    S_READ = 18'h00001, S_UL1 = 18'h00002, S_UL2 = 18'h00004, S_ER1 = 18'h00008,
    S_ER2 = 18'h00010, S_ER3 = 18'h00020, S_PROG_DATA = 18'h00040,
    S_PROG_BUSY = 18'h00080, S_BYPASS = 18'h00100, S_BYP_EXIT = 18'h00200,
    S_BULK = 18'h00400, S_SE_WIN = 18'h00800, S_SE_RUN = 18'h01000,
    S_SUSP_WAIT = 18'h02000, S_SUSPENDED = 18'h04000, S_PROT_READ = 18'h08000,
    S_FAILED = 18'h10000, S_RECOVER = 18'h20000
  } dev_state_t;

  typedef struct packed {
    dev_state_t st;
    logic byp;
    logic err;
    logic tog;
    logic phase;
    logic [2:0] tries;
    logic [13:0] tmr;
    logic [19:0] mask;
    logic [8:0] eidx;
    logic [8:0] pidx;
    logic [15:0] pdata;
    logic [15:0] rdata;
    logic rvalid;
  } dev_regs_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [19:0] sel;
    logic [13:0] rst_cnt;
    logic rst_n;
    logic pend;
    logic wr_stb;
    logic rd_stb;
    logic dph_wr;
    logic [7:0] dph_addr;
    logic [31:0] hrdata;
  } host_regs_t;
endpackage : flash_seq_pkg

// *** flash_bus_if.sv ***
`timescale 1ns/100ps
// microcontroller bus between controller and flash sequencer
interface flash_bus_if;
  logic wr_stb;
  logic rd_stb;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic rd_valid;
  logic [15:0] primary_sector_selects;
  logic [3:0] secondary_sector_selects;
  logic reset_pin_n;
  logic ready;

  modport dev (
    input wr_stb, rd_stb, addr, wdata, primary_sector_selects, secondary_sector_selects,
    input reset_pin_n,
    output rdata, rd_valid, ready
  );
  modport mcu (
    output wr_stb, rd_stb, addr, wdata, primary_sector_selects, secondary_sector_selects,
    output reset_pin_n,
    input rdata, rd_valid, ready
  );
endinterface : flash_bus_if

// *** flash_seq_dev.sv ***
`timescale 1ns/100ps
module flash_seq_dev #(
  parameter int WINDOW_CYCLES = flash_seq_pkg::WINDOW_CYC // sector erase window length
) (
  input wire logic hclk, // clock
  input wire logic hresetn, // async reset, active low
  flash_bus_if.dev bus, // microcontroller bus
  input wire logic [19:0] prot_bits, // per-sector protection, set outside the bus
  input wire logic erase_fail // forces erase verify to fail
);
  import flash_seq_pkg::*;

  localparam logic [13:0] WIN_CYC = 14'(WINDOW_CYCLES);

  dev_regs_t q;
  dev_regs_t d;
  logic [15:0] mem [MEM_WORDS];
  logic mem_we;
  logic [8:0] mem_idx;
  logic [15:0] mem_wd;
  logic [4:0] sec;
  logic sel_any;
  logic [8:0] ridx;
  logic [19:0] sec_bit;
  logic [7:0] cmd;
  logic [11:0] cadr;
  logic even;
  logic busy;
  logic [7:0] stat;
  logic [15:0] cur;

  // selected sector number; secondary sectors win on overlap
  always_comb begin
    sec = 5'h00;
    for (int i = 0; i < PRI_SECTORS; i++) begin
      if (bus.primary_sector_selects[i]) begin
        sec = 5'(i);
      end
    end
    for (int i = 0; i < SECTORS - PRI_SECTORS; i++) begin
      if (bus.secondary_sector_selects[i]) begin
        sec = 5'(PRI_SECTORS + i);
      end
    end
  end

  assign sel_any = |{bus.primary_sector_selects, bus.secondary_sector_selects};
  assign ridx = {sec, bus.addr[WORD_BITS-1:0]};
  assign sec_bit = 20'h00001 << sec;
  assign cmd = bus.wdata[7:0];
  assign cadr = bus.addr[11:0];
  assign even = ~bus.addr[0];
  assign cur = mem[ridx];
  assign busy = q.st inside {S_PROG_BUSY, S_BULK, S_SE_WIN, S_SE_RUN, S_SUSP_WAIT,
                             S_FAILED, S_RECOVER};
  assign bus.ready = ~busy;
  assign bus.rdata = q.rdata;
  assign bus.rd_valid = q.rvalid;

  // status byte seen on array reads while an operation is pending
  always_comb begin
    stat = 8'h00;
    stat[ST_POLL] = (q.st == S_PROG_BUSY) ? ~q.pdata[7] : 1'b0;
    stat[ST_TOGGLE] = q.tog;
    stat[ST_ERROR] = q.err;
    stat[ST_TIMEOUT] = (q.st != S_SE_WIN);
  end

  // sequencer next state
  always_comb begin
    d = q;
    d.rvalid = 1'b0;
    mem_we = 1'b0;
    mem_idx = q.eidx;
    mem_wd = q.phase ? ERASED_WORD : PRECHARGE_WORD;
    // reads: status while busy outside recovery, otherwise array, inverted suspended-sector or protection data
    if (bus.rd_stb) begin
      d.rvalid = 1'b1;
      if (busy && q.st != S_RECOVER) begin
        d.rdata = {stat, stat};
        d.tog = ~q.tog;
      end else if (q.st == S_SUSPENDED && q.mask[sec]) begin
        d.rdata = ~cur;
      end else if (q.st == S_PROT_READ) begin
        d.rdata = {15'h0000, prot_bits[sec]};
      end else begin
        d.rdata = cur;
      end
    end
    // timers and engines
    case (q.st)
      S_PROG_BUSY: begin
        if (q.tmr == 14'h0000) begin
          mem_we = 1'b1;
          mem_idx = q.pidx;
          mem_wd = mem[q.pidx] & q.pdata;
          if ((q.pdata & ~mem[q.pidx]) != 16'h0000) begin
            d.err = 1'b1;
            d.st = S_FAILED;
          end else begin
            d.st = q.byp ? S_BYPASS : S_READ;
          end
        end else begin
          d.tmr = q.tmr - 14'h0001;
        end
      end
      S_SE_WIN: begin
        if (q.tmr == 14'h0000) begin
          d.st = (q.mask == 20'h00000) ? S_READ : S_SE_RUN;
        end else begin
          d.tmr = q.tmr - 14'h0001;
        end
      end
      S_BULK, S_SE_RUN: begin
        // zero pass then erase pass over every masked sector
        mem_we = q.mask[q.eidx[8:4]];
        d.eidx = q.eidx + 9'h001;
        if (q.eidx == MEM_LAST) begin
          d.eidx = 9'h000;
          if (!q.phase) begin
            d.phase = 1'b1;
          end else if (erase_fail) begin
            d.phase = 1'b0;
            d.tries = q.tries + 3'h1;
            if (q.tries == ERASE_TRIES - 3'h1) begin
              d.err = 1'b1;
              d.st = S_FAILED;
            end
          end else begin
            d.mask = 20'h00000;
            d.st = S_READ;
          end
        end
      end
      S_SUSP_WAIT, S_RECOVER: begin
        if (q.tmr == 14'h0000) begin
          d.st = (q.st == S_RECOVER) ? S_READ : S_SUSPENDED;
          if (q.st == S_RECOVER) begin
            d.err = 1'b0;
          end
        end else begin
          d.tmr = q.tmr - 14'h0001;
        end
      end
      default: begin
      end
    endcase
    // instruction decode
    if (bus.wr_stb) begin
      case (q.st)
        S_READ, S_UL1, S_UL2: begin
          d.st = S_READ;
          if (cmd == CMD_RESET) begin
            d.st = q.err ? S_RECOVER : S_READ;
            d.tmr = RECOVER_CYC;
          end else if (q.st == S_READ) begin
            if (cmd == CMD_UNLOCK1 && cadr == ADDR_UNLOCK1) begin
              d.st = S_UL1;
            end
          end else if (q.st == S_UL1) begin
            if (cmd == CMD_UNLOCK2 && cadr == ADDR_UNLOCK2) begin
              d.st = S_UL2;
            end
          end else if (cmd == CMD_PROG) begin
            d.st = S_PROG_DATA;
          end else if (cmd == CMD_BYPASS) begin
            d.byp = 1'b1;
            d.st = S_BYPASS;
          end else if (cmd == CMD_ERASE_SETUP) begin
            d.st = S_ER1;
          end else if (cmd == CMD_PROT_READ) begin
            d.st = S_PROT_READ;
          end
        end
        S_ER1: begin
          d.st = (cmd == CMD_UNLOCK1 && cadr == ADDR_UNLOCK1) ? S_ER2 : S_READ;
        end
        S_ER2: begin
          d.st = (cmd == CMD_UNLOCK2 && cadr == ADDR_UNLOCK2) ? S_ER3 : S_READ;
        end
        S_ER3: begin
          d.st = S_READ;
          d.eidx = 9'h000;
          d.phase = 1'b0;
          d.tries = 3'h0;
          if (cmd == CMD_BULK) begin
            d.mask = ~prot_bits;
            d.st = S_BULK;
          end else if (cmd == CMD_SECTOR && sel_any) begin
            d.mask = sec_bit & ~prot_bits;
            d.tmr = WIN_CYC;
            d.st = S_SE_WIN;
          end
        end
        S_PROG_DATA: begin
          d.st = q.byp ? S_BYPASS : S_READ;
          if (sel_any && !prot_bits[sec]) begin
            d.pidx = ridx;
            d.pdata = bus.wdata;
            d.tmr = PROG_CYC;
            d.st = S_PROG_BUSY;
          end
        end
        S_BYPASS: begin
          // anything but program or exit is dropped
          if (cmd == CMD_PROG) begin
            d.st = S_PROG_DATA;
          end else if (cmd == CMD_BYP_EXIT1) begin
            d.st = S_BYP_EXIT;
          end
        end
        S_BYP_EXIT: begin
          d.st = S_BYPASS;
          if (cmd == CMD_BYP_EXIT2) begin
            d.byp = 1'b0;
            d.st = S_READ;
          end
        end
        S_SE_WIN: begin
          if (cmd == CMD_SECTOR && sel_any) begin
            d.mask = q.mask | (sec_bit & ~prot_bits);
            d.tmr = WIN_CYC;
          end else if (cmd == CMD_SUSPEND && even && sel_any) begin
            d.st = S_SUSP_WAIT;
            d.tmr = SUSP_CYC;
          end else if (cmd != CMD_RESUME) begin
            d.mask = 20'h00000;
            d.st = S_READ;
          end
        end
        S_SE_RUN: begin
          if (cmd == CMD_SUSPEND && even && sel_any) begin
            d.st = S_SUSP_WAIT;
            d.tmr = SUSP_CYC;
          end else if (cmd == CMD_RESET) begin
            d.mask = 20'h00000;
            d.st = S_RECOVER;
            d.tmr = RECOVER_CYC;
          end
        end
        S_SUSPENDED: begin
          if (cmd == CMD_RESUME && even && sel_any) begin
            d.st = S_SE_RUN;
          end else if (cmd == CMD_RESET) begin
            d.mask = 20'h00000;
            d.st = S_READ;
          end
        end
        S_PROT_READ: begin
          if (cmd == CMD_RESET) begin
            d.st = S_READ;
          end
        end
        S_FAILED: begin
          if (cmd == CMD_RESET) begin
            d.st = S_RECOVER;
            d.tmr = RECOVER_CYC;
          end
        end
        S_BULK: begin
          // bulk erase takes no instruction at all, reset included
        end
        default: begin
          // programming, suspend latency, recovery ignore writes
        end
      endcase
    end
    // reset pin overrides everything; busy work needs recovery time
    if (!bus.reset_pin_n) begin
      d.byp = 1'b0;
      d.mask = 20'h00000;
      d.tog = 1'b0;
      d.st = (busy || q.st == S_SUSPENDED) ? S_RECOVER : S_READ;
      d.tmr = RECOVER_CYC;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '{st: S_READ, default: '0};
    end else begin
      q <= d;
    end
  end

  // array storage, no reset: contents are undefined until erased
  always_ff @(posedge hclk) begin
    if (mem_we) begin
      mem[mem_idx] <= mem_wd;
    end
  end
endmodule : flash_seq_dev

// *** flash_seq_mcu.sv ***
`timescale 1ns/100ps
// bus controller: software drives flash bus cycles through ahb-lite registers
module flash_seq_mcu (
  input wire logic hclk, // clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write not read
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // never stalls
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  flash_bus_if.mcu bus // flash side
);
  import flash_seq_pkg::*;

  host_regs_t q;
  host_regs_t d;
  logic aph;
  logic [31:0] rmux;

  assign aph = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.hrdata;
  assign bus.wr_stb = q.wr_stb;
  assign bus.rd_stb = q.rd_stb;
  assign bus.addr = q.addr;
  assign bus.wdata = q.wdata;
  assign bus.primary_sector_selects = q.sel[15:0];
  assign bus.secondary_sector_selects = q.sel[19:16];
  assign bus.reset_pin_n = q.rst_n;

  // read mux, sampled in the address phase so data stands in the data phase
  always_comb begin
    case (haddr[7:0])
      REG_ADDR: rmux = {16'h0000, q.addr};
      REG_WDATA: rmux = {16'h0000, q.wdata};
      REG_RDATA: rmux = {16'h0000, q.rdata};
      REG_STAT: rmux = {29'h00000000, ~q.rst_n, q.pend, bus.ready};
      REG_SEL: rmux = {12'h000, q.sel};
      default: rmux = 32'h00000000;
    endcase
  end

  always_comb begin
    d = q;
    d.wr_stb = 1'b0;
    d.rd_stb = 1'b0;
    d.dph_wr = aph && hwrite;
    d.dph_addr = haddr[7:0];
    if (aph && !hwrite) begin
      d.hrdata = rmux;
    end
    // each data-register write is one flash write cycle, address/data as given
    if (q.dph_wr) begin
      case (q.dph_addr)
        REG_ADDR: d.addr = hwdata[15:0];
        REG_WDATA: begin
          d.wdata = hwdata[15:0];
          d.wr_stb = 1'b1;
        end
        REG_RDGO: begin
          d.addr = hwdata[15:0];
          d.rd_stb = 1'b1;
          d.pend = 1'b1;
        end
        REG_SEL: d.sel = hwdata[19:0];
        REG_RST: d.rst_cnt = RECOVER_CYC;
        default: begin
        end
      endcase
    end
    if (bus.rd_valid) begin
      d.rdata = bus.rdata;
      d.pend = 1'b0;
    end
    // pin pulse held the full recovery time; a busy or suspended device then recovers that long again before it is ready, an idle one is ready at once
    if (q.rst_cnt != 14'h0000) begin
      d.rst_cnt = q.rst_cnt - 14'h0001;
    end
    d.rst_n = (d.rst_cnt == 14'h0000);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '{rst_n: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end
endmodule : flash_seq_mcu

// *** flash_seq_properties.sv ***
`timescale 1ns/100ps
// watches the flash bus where both ends are design code
module flash_seq_properties (
  input wire logic hclk, // clock
  input wire logic hresetn, // async reset, active low
  input wire logic wr_stb, // write strobe
  input wire logic rd_stb, // read strobe
  input wire logic [15:0] rdata, // read data
  input wire logic rd_valid, // read answer
  input wire logic reset_pin_n, // reset pin
  input wire logic ready // device idle
);
  import flash_seq_pkg::*;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic tog_q;
  logic seen_q;
  logic stat;
  logic [13:0] rec_q;
  // status words mirror both bytes; error reads are left out of the toggle check
  assign stat = rd_valid && rdata[15:8] == rdata[7:0] && !rdata[ST_ERROR];
  // last toggle bit of this busy spell, forgotten once idle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tog_q <= 1'b0;
      seen_q <= 1'b0;
    end else if (ready) begin
      seen_q <= 1'b0;
    end else if (stat) begin
      tog_q <= rdata[ST_TOGGLE];
      seen_q <= 1'b1;
    end
  end
  // cycles since the pin let go while still recovering
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rec_q <= 14'h0000;
    end else if (!reset_pin_n) begin
      rec_q <= 14'h0001;
    end else if (ready) begin
      rec_q <= 14'h0000;
    end else if (rec_q != 14'h0000) begin
      rec_q <= rec_q + 14'h0001;
    end
  end
  a_read_answer: assert property (rd_stb |=> rd_valid ##1 !rd_valid)
    else $error("read answer not one cycle after strobe");
  a_rdata_hold: assert property ($changed(rdata) |-> rd_valid)
    else $error("read data moved without an answer");
  a_write_single: assert property (wr_stb |=> !wr_stb)
    else $error("write strobe longer than one cycle");
  a_toggle_flips: assert property (stat && !ready && seen_q |-> rdata[ST_TOGGLE] != tog_q)
    else $error("toggle bit stuck while busy");
  a_pin_hold_busy: assert property (!reset_pin_n && !ready |=> !ready)
    else $error("busy device idle while pin held");
  a_pin_idle_read: assert property (!reset_pin_n && ready |=> ready)
    else $error("idle device went busy on pin");
  a_recover_min: assert property ($rose(reset_pin_n) && !ready |-> !ready [*8])
    else $error("recovery after pin too short");
  a_recover_bound: assert property (rec_q <= RECOVER_CYC + 14'h0008)
    else $error("recovery after pin too long");
endmodule : flash_seq_properties

// *** flash_erase_bypass_reset_control_test.sv ***
`timescale 1ns/100ps
module flash_erase_bypass_reset_control_test;
  import flash_seq_pkg::*;
  localparam logic [15:0] UA = {4'h0, ADDR_UNLOCK1};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic [19:0] prot_bits = 20'h0;
  logic erase_fail = 1'b0;
  int bad_count = 0;
  int n_compared = 0;
  int polls;
  always #4 hclk = ~hclk;
  flash_bus_if flash_bus_if_inst ();
  flash_seq_mcu flash_seq_mcu_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
    .bus(flash_bus_if_inst.mcu));
  // short erase window keeps the run brief
  flash_seq_dev #(.WINDOW_CYCLES(50)) flash_seq_dev_inst (.hclk(hclk), .hresetn(hresetn),
    .bus(flash_bus_if_inst.dev), .prot_bits(prot_bits), .erase_fail(erase_fail));
  flash_seq_properties flash_seq_properties_inst (.hclk(hclk), .hresetn(hresetn),
    .wr_stb(flash_bus_if_inst.wr_stb), .rd_stb(flash_bus_if_inst.rd_stb),
    .rdata(flash_bus_if_inst.rdata), .rd_valid(flash_bus_if_inst.rd_valid),
    .reset_pin_n(flash_bus_if_inst.reset_pin_n), .ready(flash_bus_if_inst.ready));
  // one single ahb transfer, held until hready
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask : ahb
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wreg
  task automatic fw(input logic [15:0] a, input logic [15:0] d);
    wreg(REG_ADDR, {16'h0, a});
    wreg(REG_WDATA, {16'h0, d});
  endtask : fw
  task automatic fc(input logic [15:0] a, input logic [7:0] c);
    fw(a, {8'h0, c});
  endtask : fc
  // flash read: launch, wait for pending to drop, fetch
  task automatic fr(input logic [15:0] a, output logic [15:0] d);
    logic [31:0] r;
    wreg(REG_RDGO, {16'h0, a});
    r = 32'h2;
    while (r[1] !== 1'b0) ahb(1'b0, REG_STAT, 32'h0, r);
    ahb(1'b0, REG_RDATA, 32'h0, r);
    d = r[15:0];
  endtask : fr
  task automatic sel(input int n);
    wreg(REG_SEL, 32'h1 << n);
  endtask : sel
  task automatic unlock;
    fc(UA, CMD_UNLOCK1);
    fc({4'h0, ADDR_UNLOCK2}, CMD_UNLOCK2);
  endtask : unlock
  task automatic es;
    unlock();
    fc(UA, CMD_ERASE_SETUP);
    unlock();
  endtask : es
  // poll ready, counting polls of two cycles each
  task automatic idle;
    logic [31:0] r;
    r = 32'h0;
    polls = 0;
    // one edge first, so the last write strobe has reached the device
    @(posedge hclk);
    while (r[0] !== 1'b1) begin
      ahb(1'b0, REG_STAT, 32'h0, r);
      polls++;
    end
  endtask : idle
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // bulk erase with a reset that must be ignored mid-erase
  task automatic t_bulk;
    logic [15:0] d;
    sel(1);
    es();
    fc(UA, CMD_BULK);
    fc(UA, CMD_RESET);
    idle();
    chk(16'(polls > MEM_WORDS / 2 && polls < 1000), 16'h1);
    fr(16'h0, d);
    chk(d, ERASED_WORD);
  endtask : t_bulk
  // wrong sixth cycle, then a stray write inside the window
  task automatic t_abort;
    logic [15:0] d;
    for (int i = 0; i < 2; i++) begin
      es();
      if (i == 1) fc(16'h0, CMD_SECTOR);
      fw(16'h0, 16'h0077);
      if (i == 0) fc(16'h0, CMD_SECTOR);
      fr(16'h0, d);
      chk(d, ERASED_WORD);
    end
  endtask : t_abort
  task automatic t_bypass;
    logic [15:0] d;
    prot_bits <= 20'h00004;
    unlock();
    fc(UA, CMD_BYPASS);
    fc(16'h0, CMD_PROG);
    fw(16'h0, 16'h1234);
    idle();
    es();
    fc(16'h0, CMD_PROG);
    fw(16'h1, 16'h5678);
    idle();
    sel(2);
    fc(16'h0, CMD_PROG);
    fw(16'h0, 16'h4321);
    idle();
    fc(16'h0, CMD_BYP_EXIT1);
    fc(16'h7, CMD_BYP_EXIT2);
    fr(16'h0, d);
    chk(d, ERASED_WORD);
    sel(1);
    fc(16'h0, CMD_PROG);
    fw(16'h2, 16'h1111);
    fr(16'h0, d);
    chk(d, 16'h1234);
    fr(16'h1, d);
    chk(d, 16'h5678);
    fr(16'h2, d);
    chk(d, ERASED_WORD);
  endtask : t_bypass
  // two sectors queued, suspended inside the window, then resumed
  task automatic t_suspend;
    logic [15:0] d;
    es();
    fc(16'h0, CMD_SECTOR);
    sel(3);
    fc(16'h0, CMD_SECTOR);
    fr(16'h0, d);
    chk(16'(d[ST_TIMEOUT]), 16'h0);
    chk({8'h0, d[15:8]}, {8'h0, d[7:0]});
    sel(1);
    fc(16'h0, CMD_SUSPEND);
    repeat (16) @(posedge hclk);
    fr(16'h0, d);
    chk(d, ~16'h1234);
    sel(0);
    fr(16'h3, d);
    chk(d, ERASED_WORD);
    unlock();
    fc(UA, CMD_PROG);
    fw(16'h3, 16'h0000);
    fr(16'h3, d);
    chk(d, ERASED_WORD);
    sel(1);
    fc(16'h0, CMD_RESUME);
    idle();
    fr(16'h1, d);
    chk(d, ERASED_WORD);
  endtask : t_suspend
  // running sector erase cut by the reset write or the reset pin
  task automatic t_run(input int i);
    logic [15:0] d;
    sel(0);
    es();
    fc(16'h0, CMD_SECTOR);
    d = 16'h0;
    while (d[ST_TIMEOUT] !== 1'b1) fr(16'h0, d);
    fw(16'h0, 16'h0077);
    fr(16'h0, d);
    chk(16'(d[ST_TIMEOUT]), 16'h1);
    if (i == 0) fc(16'h0, CMD_RESET);
    else wreg(REG_RST, 32'h0);
    idle();
    chk(16'(polls > 1000), 16'h1);
  endtask : t_run
  // erase that keeps failing sets the error flag until a reset
  task automatic t_fail;
    logic [15:0] d;
    erase_fail <= 1'b1;
    sel(3);
    es();
    fc(16'h0, CMD_SECTOR);
    d = 16'h0;
    while (d[ST_ERROR] !== 1'b1) fr(16'h0, d);
    chk(16'(d[ST_ERROR + 8]), 16'h1);
    erase_fail <= 1'b0;
    fc(16'h0, CMD_RESET);
    idle();
    chk(16'(polls > 1000), 16'h1);
  endtask : t_fail
  // protection read, reset with no error, reset and suspend that must not act
  task automatic t_prot;
    logic [15:0] d;
    unlock();
    fc(UA, CMD_PROT_READ);
    sel(2);
    fr(16'h0, d);
    chk(d, 16'h0001);
    sel(1);
    fr(16'h0, d);
    chk(d, 16'h0000);
    fc(16'h0, CMD_RESET);
    idle();
    chk(16'(polls), 16'h1);
    unlock();
    fc(UA, CMD_PROG);
    fw(16'h4, 16'h00a5);
    fc(16'h0, CMD_RESET);
    idle();
    fc(16'h0, CMD_SUSPEND);
    unlock();
    fc(UA, CMD_PROG);
    fw(16'h5, 16'h005a);
    idle();
    fr(16'h4, d);
    chk(d, 16'h00a5);
    fr(16'h5, d);
    chk(d, 16'h005a);
  endtask : t_prot
  task automatic summarize;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize
  // cut a hang well past the expected run length
  initial begin
    repeat (90000) @(posedge hclk);
    bad_count++;
    $display("unexpected at %0t: timeout", $time);
    summarize();
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_bulk();
    t_abort();
    t_bypass();
    t_suspend();
    t_run(0);
    t_run(1);
    t_fail();
    t_prot();
    summarize();
  end
endmodule : flash_erase_bypass_reset_control_test
